// *** fsmw_pkg.sv ***
// constants, register map and types of the sync monitor and wakeup block
package fsmw_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL      = 12'h000;
    localparam logic [11:0] OFS_SLEEP     = 12'h004;
    localparam logic [11:0] OFS_SYNC_STAT = 12'h008;
    localparam logic [11:0] OFS_SYNC_CFG  = 12'h00c;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h010;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h014;
    localparam logic [11:0] OFS_LIST_CNT  = 12'h018;
    localparam logic [11:0] OFS_LIST_BASE = 12'h100;
    localparam logic [11:0] LIST_SPAN     = 12'h100;

    // control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_TERM_BIT  = 1;
    localparam int CTRL_WCH_BIT   = 2;
    localparam int CTRL_REP_LSB   = 8;
    localparam int REP_W          = 6;
    localparam logic [5:0] REP_MIN = 6'h02;
    localparam logic [5:0] REP_MAX = 6'h3f;
    localparam logic [5:0] REP_RST = 6'h02;
    localparam logic       TERM_RST = 1'b0;
    localparam logic       WCH_A    = 1'b0;
    localparam logic       WCH_B    = 1'b1;

    // sync count configuration fields
    localparam int CFG_MIN_LSB = 0;
    localparam int CFG_MAX_LSB = 8;
    localparam int CNT_W       = 4;
    localparam logic [3:0] SYNC_MIN_RST = 4'h2;
    localparam logic [3:0] SYNC_MAX_RST = 4'hf;

    // interrupt bits
    localparam int IRQ_W         = 4;
    localparam int IRQ_BELOW     = 0;
    localparam int IRQ_OVER      = 1;
    localparam int IRQ_WAKE_DONE = 2;
    localparam int IRQ_WAKE_COLL = 3;

    // list geometry
    localparam int SLOT_W     = 11;
    localparam int LIST_DEPTH = 16;
    localparam int IDX_W      = 4;
    localparam int LCNT_W     = 5;
    localparam int LCNT_LSB   = 8;

    // wakeup symbol timing
    localparam int CLK_MHZ     = 200;
    localparam int WUS_LOW_NS  = 6000;
    localparam int WUS_IDLE_NS = 18000;
    localparam int PH_W        = 12;
    localparam logic [11:0] WUS_LOW_CYC  = 12'((WUS_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] WUS_IDLE_CYC = 12'((WUS_IDLE_NS * CLK_MHZ + 999) / 1000);

    typedef enum logic [1:0] {
        SLP_LOCAL_SLEEP = 2'h0,
        SLP_LOCAL_WAKE  = 2'h1,
        SLP_REMOTE_WAKE = 2'h2
    } fsmw_sleep_e;

    typedef enum logic [1:0] {
        SST_WITHIN = 2'h0,
        SST_BELOW  = 2'h1,
        SST_OVER   = 2'h2,
        SST_BOTH   = 2'h3
    } fsmw_sync_e;

    typedef enum logic [2:0] {
        WK_ASLEEP    = 3'b000,
        WK_PENDING   = 3'b001,
        WK_SEND_LOW  = 3'b010,
        WK_SEND_IDLE = 3'b011,
        WK_AWAKE     = 3'b100
    } fsmw_wake_e;
endpackage

// *** fsmw_slot_mem.sv ***
// slot id memory with registered read port
`timescale 1ns/10ps
module fsmw_slot_mem #(
    parameter int DATA_W = 11,
    parameter int ADDR_W = 6
) (
    // clock
    input  wire logic              core_clk,
    // write port
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    // read port
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // storage write
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read
    always_ff @(posedge core_clk) begin
        rdata <= mem[raddr];
    end
endmodule // fsmw_slot_mem

// *** fsmw_top.sv ***
// sync frame monitor and wakeup sender with ahb-lite registers
`timescale 1ns/10ps
module fsmw_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // protocol events
    input  wire logic        cycle_start,
    input  wire logic        cycle_odd,
    input  wire logic        sync_frame,
    input  wire logic [10:0] sync_slot,
    input  wire logic        sync_on_a,
    input  wire logic        sync_on_b,
    // bus pins
    input  wire logic        rx_idle_a,
    input  wire logic        rx_idle_b,
    output logic             wake_drive_a,
    output logic             wake_drive_b,
    output logic             bus_termination_enable,
    output logic             integrate_req,
    output logic             awake,
    output logic             irq
);
    localparam int MA_W = fsmw_pkg::IDX_W + 2;

    logic started, wake_ch, wake_ch_q;
    logic [5:0] rep_cnt;
    logic [3:0] sync_min, sync_max;
    logic dp_wr, dp_list, dp_ok, dp_ch;
    logic [11:0] dp_addr;
    logic [31:0] dp_rdata;
    logic in_cycle, cur_par, below_flag, over_flag;
    logic [5:0] cyc_cnt;
    logic [1:0][4:0] cur_cnt;
    logic [1:0][1:0][4:0] pub_cnt;
    logic [1:0][1:0] pub_half;
    logic [1:0][MA_W-1:0] mem_raddr;
    logic [1:0][10:0] mem_rdata;
    logic [1:0] mem_we;
    logic [3:0] irq_stat, irq_mask, evt;
    fsmw_pkg::fsmw_wake_e wk_state, next_wk_state;
    logic [11:0] ph_cnt;
    logic [5:0] syms_left, sym_seen;
    logic a_valid, wr_ctrl, wr_sleep, wr_cfg, start_pulse, close_cyc;
    logic below_evt, over_evt, done_evt, coll_evt, coll;
    logic [1:0] lsel;
    fsmw_pkg::fsmw_sync_e sync_status;

    // register address match in the data phase
    function automatic logic hit(input logic [11:0] ofs);
        return dp_wr && dp_addr == ofs;
    endfunction

    // bus decode; slave never stalls and always answers okay
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign a_valid     = hsel && htrans[1] && hready;
    assign wr_ctrl     = hit(fsmw_pkg::OFS_CTRL);
    assign wr_sleep    = hit(fsmw_pkg::OFS_SLEEP);
    assign wr_cfg      = hit(fsmw_pkg::OFS_SYNC_CFG);
    assign start_pulse = wr_ctrl && hwdata[fsmw_pkg::CTRL_START_BIT] && !started;
    assign close_cyc   = cycle_start && in_cycle && started;
    assign lsel        = haddr[7:6];

    // address phase capture
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dp_wr   <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            dp_wr   <= a_valid && hwrite;
            dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    // control and configuration, locked once started
    always_ff @(posedge core_clk) begin
        if (srst) begin
            started   <= 1'b0;
            bus_termination_enable <= fsmw_pkg::TERM_RST;
            wake_ch   <= fsmw_pkg::WCH_A;
            rep_cnt   <= fsmw_pkg::REP_RST;
            sync_min  <= fsmw_pkg::SYNC_MIN_RST;
            sync_max  <= fsmw_pkg::SYNC_MAX_RST;
        end else begin
            if (wr_ctrl) begin
                started <= hwdata[fsmw_pkg::CTRL_START_BIT];
            end
            if (wr_ctrl && !started) begin
                bus_termination_enable <= hwdata[fsmw_pkg::CTRL_TERM_BIT];
                wake_ch <= hwdata[fsmw_pkg::CTRL_WCH_BIT];
                if (hwdata[13:8] >= fsmw_pkg::REP_MIN) begin
                    rep_cnt <= hwdata[fsmw_pkg::CTRL_REP_LSB +: fsmw_pkg::REP_W];
                end
            end
            if (wr_cfg && !started) begin
                sync_min <= hwdata[fsmw_pkg::CFG_MIN_LSB +: fsmw_pkg::CNT_W];
                sync_max <= hwdata[fsmw_pkg::CFG_MAX_LSB +: fsmw_pkg::CNT_W];
            end
        end
    end

    // cycle tracking and per-cycle sync count
    always_ff @(posedge core_clk) begin
        if (srst || start_pulse || !started) begin
            in_cycle <= 1'b0;
            cur_par  <= 1'b0;
            cyc_cnt  <= 6'h00;
        end else if (cycle_start) begin
            in_cycle <= 1'b1;
            cur_par  <= cycle_odd;
            cyc_cnt  <= 6'h00;
        end else if (sync_frame && in_cycle && cyc_cnt != 6'h3f) begin
            cyc_cnt  <= cyc_cnt + 6'h01;
        end
    end

    // count limits checked as each cycle closes
    assign below_evt = close_cyc && cyc_cnt < {2'b00, sync_min};
    assign over_evt  = close_cyc && cyc_cnt > {2'b00, sync_max};

    // sticky error flags, cleared only by a start
    always_ff @(posedge core_clk) begin
        if (srst || start_pulse) begin
            below_flag <= 1'b0;
            over_flag  <= 1'b0;
        end else begin
            below_flag <= below_flag || below_evt;
            over_flag  <= over_flag || over_evt;
        end
    end

    // status is within limits while stopped
    assign sync_status = !started ? fsmw_pkg::SST_WITHIN
                       : fsmw_pkg::fsmw_sync_e'({over_flag, below_flag});

    // list building: write the hidden half, publish on cycle close
    always_ff @(posedge core_clk) begin
        if (srst || start_pulse) begin
            cur_cnt  <= '0;
            pub_cnt  <= '0;
            pub_half <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (close_cyc) begin
                    pub_cnt[c][cur_par]  <= cur_cnt[c];
                    pub_half[c][cur_par] <= !pub_half[c][cur_par];
                    cur_cnt[c]           <= 5'h00;
                end else if (cycle_start) begin
                    cur_cnt[c] <= 5'h00;
                end else if (mem_we[c]) begin
                    cur_cnt[c] <= cur_cnt[c] + 5'h01;
                end
            end
        end
    end

    // one slot memory per channel
    generate
        for (genvar g = 0; g < 2; g++) begin : g_chan
            logic on_ch;
            assign on_ch = (g == 0) ? sync_on_a : sync_on_b;
            assign mem_we[g] = sync_frame && on_ch && in_cycle && !cycle_start
                               && cur_cnt[g] < 5'(fsmw_pkg::LIST_DEPTH);
            assign mem_raddr[g] = {lsel[0], pub_half[g][lsel[0]], haddr[5:2]};
            fsmw_slot_mem #(
                .DATA_W (fsmw_pkg::SLOT_W),
                .ADDR_W (MA_W)
            ) u_mem (
                .core_clk (core_clk),
                .we       (mem_we[g]),
                .waddr    ({cur_par, !pub_half[g][cur_par], cur_cnt[g][3:0]}),
                .wdata    (sync_slot),
                .raddr    (mem_raddr[g]),
                .rdata    (mem_rdata[g])
            );
        end
    endgenerate

    // read data prepared in the address phase
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dp_list  <= 1'b0;
            dp_ok    <= 1'b0;
            dp_ch    <= 1'b0;
            dp_rdata <= 32'h0000_0000;
        end else begin
            dp_list  <= haddr[11:8] == fsmw_pkg::OFS_LIST_BASE[11:8];
            dp_ch    <= lsel[1];
            dp_ok    <= started && {1'b0, haddr[5:2]} < pub_cnt[lsel[1]][lsel[0]];
            dp_rdata <= 32'h0000_0000;
            unique case ({haddr[11:2], 2'b00})
                fsmw_pkg::OFS_CTRL:      dp_rdata <= {18'h0, rep_cnt, 5'h0, wake_ch,
                                                      bus_termination_enable, started};
                fsmw_pkg::OFS_SYNC_STAT: dp_rdata <= {30'h0, sync_status};
                fsmw_pkg::OFS_SYNC_CFG:  dp_rdata <= {20'h0, sync_max, 4'h0, sync_min};
                fsmw_pkg::OFS_IRQ_STAT:  dp_rdata <= {28'h0, irq_stat};
                fsmw_pkg::OFS_IRQ_MASK:  dp_rdata <= {28'h0, irq_mask};
                fsmw_pkg::OFS_LIST_CNT:  if (started) begin
                    dp_rdata <= {3'h0, pub_cnt[1][1], 3'h0, pub_cnt[1][0],
                                 3'h0, pub_cnt[0][1], 3'h0, pub_cnt[0][0]};
                end
                default:                 dp_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // list entries come straight from the memory output register
    assign hrdata = !dp_list ? dp_rdata
                  : dp_ok ? {21'h0, mem_rdata[dp_ch]} : 32'h0000_0000;

    // wakeup state machine
    assign coll = (wake_ch_q == fsmw_pkg::WCH_A) ? !rx_idle_a : !rx_idle_b;
    always_comb begin
        next_wk_state = wk_state;
        unique case (wk_state)
            fsmw_pkg::WK_ASLEEP: begin
                if (wr_sleep && hwdata[1:0] == fsmw_pkg::SLP_LOCAL_WAKE) begin
                    next_wk_state = fsmw_pkg::WK_AWAKE;
                end else if (wr_sleep && hwdata[1:0] == fsmw_pkg::SLP_REMOTE_WAKE) begin
                    next_wk_state = started ? fsmw_pkg::WK_SEND_LOW
                                  : fsmw_pkg::WK_PENDING;
                end
            end
            fsmw_pkg::WK_PENDING: begin
                if (wr_sleep && hwdata[1:0] == fsmw_pkg::SLP_LOCAL_SLEEP) begin
                    next_wk_state = fsmw_pkg::WK_ASLEEP;
                end else if (started) begin
                    next_wk_state = fsmw_pkg::WK_SEND_LOW;
                end
            end
            fsmw_pkg::WK_SEND_LOW: begin
                if (ph_cnt == fsmw_pkg::WUS_LOW_CYC - 12'h001) begin
                    next_wk_state = fsmw_pkg::WK_SEND_IDLE;
                end
            end
            fsmw_pkg::WK_SEND_IDLE: begin
                if (coll) begin
                    next_wk_state = fsmw_pkg::WK_AWAKE;
                end else if (ph_cnt == fsmw_pkg::WUS_IDLE_CYC - 12'h001) begin
                    next_wk_state = (syms_left == 6'h01) ? fsmw_pkg::WK_AWAKE
                                  : fsmw_pkg::WK_SEND_LOW;
                end
            end
            fsmw_pkg::WK_AWAKE: begin
                if (wr_sleep && hwdata[1:0] == fsmw_pkg::SLP_LOCAL_SLEEP) begin
                    next_wk_state = fsmw_pkg::WK_ASLEEP;
                end
            end
            default: next_wk_state = fsmw_pkg::WK_ASLEEP;
        endcase
    end

    assign coll_evt = wk_state == fsmw_pkg::WK_SEND_IDLE && coll;
    assign done_evt = wk_state == fsmw_pkg::WK_SEND_IDLE && !coll
                      && next_wk_state == fsmw_pkg::WK_AWAKE;

    // wakeup sequencing registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wk_state      <= fsmw_pkg::WK_ASLEEP;
            ph_cnt        <= 12'h000;
            syms_left     <= 6'h00;
            wake_ch_q     <= fsmw_pkg::WCH_A;
            wake_drive_a  <= 1'b0;
            wake_drive_b  <= 1'b0;
            integrate_req <= 1'b0;
            awake         <= 1'b0;
        end else begin
            wk_state <= next_wk_state;
            ph_cnt   <= (next_wk_state != wk_state) ? 12'h000 : ph_cnt + 12'h001;
            // load only on entry from asleep or pending, not on every low cycle
            if (next_wk_state == fsmw_pkg::WK_SEND_LOW
                && (wk_state == fsmw_pkg::WK_ASLEEP || wk_state == fsmw_pkg::WK_PENDING)) begin
                syms_left <= rep_cnt;
                wake_ch_q <= wake_ch;
            end else if (wk_state == fsmw_pkg::WK_SEND_IDLE
                         && next_wk_state == fsmw_pkg::WK_SEND_LOW) begin
                syms_left <= syms_left - 6'h01;
            end
            wake_drive_a  <= next_wk_state == fsmw_pkg::WK_SEND_LOW
                             && (wk_state == fsmw_pkg::WK_SEND_LOW
                                 || wk_state == fsmw_pkg::WK_SEND_IDLE ? wake_ch_q : wake_ch)
                                == fsmw_pkg::WCH_A;
            wake_drive_b  <= next_wk_state == fsmw_pkg::WK_SEND_LOW
                             && (wk_state == fsmw_pkg::WK_SEND_LOW
                                 || wk_state == fsmw_pkg::WK_SEND_IDLE ? wake_ch_q : wake_ch)
                                == fsmw_pkg::WCH_B;
            integrate_req <= next_wk_state == fsmw_pkg::WK_AWAKE
                             && wk_state != fsmw_pkg::WK_AWAKE;
            awake         <= next_wk_state != fsmw_pkg::WK_ASLEEP;
        end
    end

    // interrupt status, write one to clear, set wins
    assign evt = {coll_evt, done_evt, over_evt, below_evt};
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_stat <= 4'h0;
            irq_mask <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~(hit(fsmw_pkg::OFS_IRQ_STAT) ? hwdata[3:0] : 4'h0)) | evt;
            if (hit(fsmw_pkg::OFS_IRQ_MASK)) begin
                irq_mask <= hwdata[3:0];
            end
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // symbol counter seen by the checks only
    always_ff @(posedge core_clk) begin
        if (srst || wk_state == fsmw_pkg::WK_ASLEEP) begin
            sym_seen <= 6'h00;
        end else if ((wake_drive_a || wake_drive_b) && ph_cnt == 12'h000) begin
            sym_seen <= sym_seen + 6'h01;
        end
    end

    list_empty_a: assert property (@(posedge core_clk) disable iff (srst)
        (a_valid && !hwrite && !started && haddr[11:8] == 4'h1) |=> hrdata == 32'h0)
        else $error("list read not empty while stopped");
    below_set_a: assert property (@(posedge core_clk) disable iff (srst)
        below_evt |=> below_flag && sync_status[0])
        else $error("below minimum not flagged");
    over_set_a: assert property (@(posedge core_clk) disable iff (srst)
        over_evt |=> over_flag && sync_status[1])
        else $error("overflow not flagged");
    both_code_a: assert property (@(posedge core_clk) disable iff (srst)
        (started && below_flag && over_flag) |-> sync_status == fsmw_pkg::SST_BOTH)
        else $error("combined status wrong");
    stop_within_a: assert property (@(posedge core_clk) disable iff (srst)
        !started |-> sync_status == fsmw_pkg::SST_WITHIN)
        else $error("status not within limits while stopped");
    flag_sticky_a: assert property (@(posedge core_clk) disable iff (srst)
        (below_flag && !start_pulse) |=> below_flag)
        else $error("below flag dropped without start");
    cfg_locked_a: assert property (@(posedge core_clk) disable iff (srst)
        (started && $past(started)) |-> $stable(wake_ch) && $stable(rep_cnt)
            && $stable(bus_termination_enable))
        else $error("setting changed while started");
    drive_chan_a: assert property (@(posedge core_clk) disable iff (srst)
        (wk_state == fsmw_pkg::WK_SEND_LOW) |-> (wake_drive_b == wake_ch_q)
            && (wake_drive_a != wake_ch_q))
        else $error("wakeup driven on wrong channel");
    sym_count_a: assert property (@(posedge core_clk) disable iff (srst)
        done_evt |-> sym_seen == rep_cnt)
        else $error("wrong number of wakeup symbols");
    local_wake_a: assert property (@(posedge core_clk) disable iff (srst)
        (wk_state == fsmw_pkg::WK_ASLEEP && wr_sleep && hwdata[1:0] == 2'h1)
            |=> wk_state == fsmw_pkg::WK_AWAKE && !wake_drive_a && !wake_drive_b)
        else $error("local wake misbehaved");
endmodule // fsmw_top

// *** fsmw_cluster.sv ***
// cluster model: other nodes giving cycle starts and sync frames
`timescale 1ns/10ps
module fsmw_cluster (
    // clock
    input  wire logic        core_clk,
    // protocol events
    output logic             cycle_start,
    output logic             cycle_odd,
    output logic             sync_frame,
    output logic      [10:0] sync_slot,
    output logic             sync_on_a,
    output logic             sync_on_b,
    // bus idle levels
    output logic             rx_idle_a,
    output logic             rx_idle_b
);
    // quiet bus until a cycle is asked for
    initial begin
        {cycle_start, cycle_odd, sync_frame, sync_on_a, sync_on_b} = 5'h0;
        sync_slot = 11'h0;
        {rx_idle_a, rx_idle_b} = 2'h3;
    end
    // one cycle: start pulse, then n frames on channels ch (bit0 a, bit1 b)
    task automatic run(input logic odd, input int n, input logic [10:0] base,
                       input logic [1:0] ch);
        @(posedge core_clk);
        cycle_start <= 1'b1;
        cycle_odd   <= odd;
        @(posedge core_clk);
        cycle_start <= 1'b0;
        for (int k = 0; k < n; k++) begin
            sync_frame <= 1'b1;
            sync_slot  <= base + 11'(k);
            {sync_on_b, sync_on_a} <= ch;
            @(posedge core_clk);
        end
        sync_frame <= 1'b0;
        sync_slot  <= ~sync_slot; // stale slot id is not held
    endtask
    // another node pulls channel b busy for one cycle
    task automatic collide();
        @(posedge core_clk);
        rx_idle_b <= 1'b0;
        @(posedge core_clk);
        rx_idle_b <= 1'b1;
    endtask
endmodule // fsmw_cluster

// *** fsmw_top_tb.sv ***
// self-checking bench for the sync monitor and wakeup block
`timescale 1ns/10ps
module fsmw_top_tb;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic        hreadyout, hresp, cs, co, sf, sa, sb, ria, rib;
    logic        wda, wdb, term, intg, awake, irq;
    logic [10:0] ss, b1, b2;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          ha, hb;

    // 200 mhz clock
    always #2.5 core_clk = ~core_clk;

    fsmw_cluster i_cl (.core_clk(core_clk), .cycle_start(cs), .cycle_odd(co),
        .sync_frame(sf), .sync_slot(ss), .sync_on_a(sa), .sync_on_b(sb),
        .rx_idle_a(ria), .rx_idle_b(rib));

    fsmw_top i_dut (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cycle_start(cs), .cycle_odd(co), .sync_frame(sf), .sync_slot(ss),
        .sync_on_a(sa), .sync_on_b(sb), .rx_idle_a(ria), .rx_idle_b(rib),
        .wake_drive_a(wda), .wake_drive_b(wdb), .bus_termination_enable(term),
        .integrate_req(intg), .awake(awake), .irq(irq));

    // expected control word and list address
    function automatic logic [31:0] cw(input logic s, t, c, input logic [5:0] r);
        return {18'h0, r, 5'h0, c, t, s};
    endfunction
    function automatic logic [11:0] la(input int l, input int i);
        return 12'h100 + 12'(l * 64 + i * 4);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one ahb-lite single transfer, read data left in rd
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {20'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    // main sequence
    initial begin
        b1 = 11'($urandom(32'hca52));
        b2 = 11'($urandom());
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        chk({hreadyout, hresp, term, awake, irq}, 5'h10);
        rchk(fsmw_pkg::OFS_CTRL, cw(0, 0, 0, 6'h2));
        rchk(12'h020, 32'h0);
        bus(1'b1, fsmw_pkg::OFS_SYNC_CFG, 32'h0302);
        bus(1'b1, fsmw_pkg::OFS_CTRL, cw(0, 1, 1, 6'h2));
        bus(1'b1, fsmw_pkg::OFS_CTRL, cw(1, 1, 1, 6'h2));
        bus(1'b1, fsmw_pkg::OFS_CTRL, cw(1, 0, 0, 6'h5));
        rchk(fsmw_pkg::OFS_CTRL, cw(1, 1, 1, 6'h2));
        chk(term, 1'b1);
        i_cl.run(1'b0, 3, b1, 2'h3);
        i_cl.run(1'b1, 1, b1, 2'h1);
        rchk(fsmw_pkg::OFS_SYNC_STAT, 32'h0);
        i_cl.run(1'b0, 4, b2, 2'h2);
        rchk(fsmw_pkg::OFS_SYNC_STAT, 32'h1);
        i_cl.run(1'b1, 0, b2, 2'h0);
        rchk(fsmw_pkg::OFS_SYNC_STAT, 32'h3);
        rchk(fsmw_pkg::OFS_LIST_CNT, 32'h0004_0100);
        rchk(la(1, 0), {21'h0, b1});
        rchk(la(1, 1), 32'h0);
        for (int i = 0; i < 4; i++) rchk(la(2, i), {21'h0, b2 + 11'(i)});
        rchk(la(3, 0), 32'h0);
        rchk(fsmw_pkg::OFS_IRQ_STAT, 32'h3);
        bus(1'b1, fsmw_pkg::OFS_IRQ_MASK, 32'h7);
        #1 chk(irq, 1'b1);
        bus(1'b1, fsmw_pkg::OFS_IRQ_STAT, 32'h3);
        #1 chk(irq, 1'b0);
        bus(1'b1, fsmw_pkg::OFS_CTRL, cw(0, 1, 1, 6'h2));
        rchk(fsmw_pkg::OFS_SYNC_STAT, 32'h0);
        rchk(fsmw_pkg::OFS_LIST_CNT, 32'h0);
        rchk(la(2, 0), 32'h0);
        bus(1'b1, fsmw_pkg::OFS_CTRL, cw(1, 1, 1, 6'h2));
        i_cl.run(1'b0, 4, b1, 2'h1);
        i_cl.run(1'b1, 0, b1, 2'h0);
        rchk(fsmw_pkg::OFS_SYNC_STAT, 32'h2);
        bus(1'b1, fsmw_pkg::OFS_SLEEP, 32'h2);
        ha = 0;
        hb = 0;
        for (int t = 0; t < 12000 && intg !== 1'b1; t++) begin
            @(negedge core_clk);
            ha += (wda === 1'b1) ? 1 : 0;
            hb += (wdb === 1'b1) ? 1 : 0;
        end
        chk(hb, 2400);
        chk(ha, 0);
        @(negedge core_clk);
        chk({awake, irq}, 2'h3);
        rchk(fsmw_pkg::OFS_IRQ_STAT, 32'h6);
        bus(1'b1, fsmw_pkg::OFS_SLEEP, 32'h0);
        #1 chk(awake, 1'b0);
        bus(1'b1, fsmw_pkg::OFS_SLEEP, 32'h1);
        @(negedge core_clk);
        chk({awake, wda, wdb}, 3'h4);
        bus(1'b1, fsmw_pkg::OFS_SLEEP, 32'h0);
        bus(1'b1, fsmw_pkg::OFS_SLEEP, 32'h2);
        repeat (1300) @(posedge core_clk);
        i_cl.collide();
        repeat (2) @(posedge core_clk);
        rchk(fsmw_pkg::OFS_IRQ_STAT, 32'he);
        chk(awake, 1'b1);
        final_report();
    end
endmodule // fsmw_top_tb
